// ---- sdio_consts.vh ----
`ifndef SDIO_CONSTS_VH
`define SDIO_CONSTS_VH
// Register byte offsets
`define SDIO_OFF_CTRL 12'h000
`define SDIO_OFF_WINDOW 12'h004
`define SDIO_OFF_LIMIT 12'h008
`define SDIO_OFF_DEV 12'h00C
`define SDIO_OFF_STATUS 12'h010
`define SDIO_OFF_IRQ_STAT 12'h014
`define SDIO_OFF_IRQ_MASK 12'h018
`define SDIO_OFF_ALARM 12'h01C
`define SDIO_OFF_IPOS 12'h020
// Control fields
`define SDIO_CTRL_DIRSRC 0
`define SDIO_CTRL_POSMODE 1
`define SDIO_CTRL_MAINPWR 2
`define SDIO_CTRL_RESET 32'h0000_0000
// Status fields
`define SDIO_ST_READY 0
`define SDIO_ST_ALARM 1
`define SDIO_ST_INPOS 2
`define SDIO_ST_LOCK 3
`define SDIO_ST_REVERSE 4
`define SDIO_ST_HOMING 5
`define SDIO_ST_HOMED 6
`define SDIO_ST_IPOS_RUN 7
// Interrupt events
`define SDIO_EV_DEVIATION 0
`define SDIO_EV_HOME_FOUND 1
`define SDIO_EV_IPOS_START 2
`define SDIO_EV_READY 3
`define SDIO_EV_W 4
// Alarm code for excess deviation
`define SDIO_ALARM_DEV_CODE 8'h08
`define SDIO_WINDOW_RESET 32'h0000_000A
`define SDIO_LIMIT_RESET 32'h0000_7530
// Timing
`define SDIO_CLK_HZ 10000000
`define SDIO_READY_MS 1500
`define SDIO_READY_CYCLES ((`SDIO_CLK_HZ / 1000) * `SDIO_READY_MS)
`endif

// ---- sdio_sync.v ----
`timescale 1ns/1ps
module sdio_sync #(
    parameter W = 6
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Data
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_reg;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// ---- sdio_ready_timer.v ----
`timescale 1ns/1ps
`include "sdio_consts.vh"
module sdio_ready_timer #(
    parameter [31:0] CYCLES = `SDIO_READY_CYCLES
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Control
    input wire run,
    output reg done
);
    reg [31:0] cnt_reg;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 32'h0000_0000;
            done <= 1'b0;
        end else if (!run) begin
            // Any drop restarts the full delay
            cnt_reg <= 32'h0000_0000;
            done <= 1'b0;
        end else if (cnt_reg >= CYCLES - 32'h0000_0001) begin
            done <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
        end
    end
endmodule

// ---- sdio_top.v ----
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "sdio_consts.vh"
// How it works
// - Direction source 0: invert input sets direction; select pair ignored.
// - Direction source 1: select pair sets direction; invert input ignored.
// - Pair mode: only A on gives CCW; both off or both on lock.
// - Pair mode: only B on gives CW.
// - Invert mode: off follows command, on reverses it.
// - Internal position start input begins run using its parameter.
// - Ready 1.5 s after main power with no alarm, else off.
// - Alarm output on while any alarm code is active.
// - Position mode: complete while abs deviation within window.
// - Deviation above limit raises alarm code 8.
module sdio_top #(
    parameter [31:0] READY_CYCLES = `SDIO_READY_CYCLES
) (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Controller inputs
    input wire direction_invert_in,
    input wire dir_select_a,
    input wire dir_select_b,
    input wire homing_start_in,
    input wire home_reference_in,
    input wire internal_position_start_in,
    // Motion core
    input wire cmd_dir_in,
    input wire signed [31:0] position_deviation_in,
    input wire [7:0] ext_alarm_code_in,
    output reg motor_dir_out,
    output reg motor_lock_out,
    output reg homing_active_out,
    output reg internal_position_run_out,
    output reg [31:0] internal_position_param_out,
    // Controller outputs
    output reg servo_ready_out,
    output reg alarm_out,
    output reg position_complete_out,
    output reg [7:0] alarm_code_out,
    output wire irq
);
    reg [31:0] ctrl_reg;
    reg [31:0] window_reg;
    reg [31:0] limit_reg;
    reg [31:0] ipos_reg;
    reg [`SDIO_EV_W-1:0] irq_stat_reg;
    reg [`SDIO_EV_W-1:0] irq_mask_reg;
    reg excess_deviation_alarm;
    reg homed_reg;
    reg home_prev_reg;
    reg ipos_prev_reg;
    reg ready_prev_reg;
    reg [`SDIO_EV_W-1:0] ev_next;
    reg [31:0] abs_dev;
    reg dir_next;
    reg lock_next;
    wire [5:0] pins_s;
    wire ready_done;
    wire alarm_any;
    wire wr_en;
    wire rd_en;
    wire dir_src;
    wire pos_mode;
    wire main_pwr;
    wire inv_s;
    wire sel_a_s;
    wire sel_b_s;
    wire hstart_s;
    wire href_s;
    wire ipos_s;
    wire [31:0] status_w;

    // Pins come from another domain
    sdio_sync #(.W(6)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({internal_position_start_in, home_reference_in,
            homing_start_in, dir_select_b, dir_select_a,
            direction_invert_in}),
        .q(pins_s)
    );
    assign inv_s = pins_s[0];
    assign sel_a_s = pins_s[1];
    assign sel_b_s = pins_s[2];
    assign hstart_s = pins_s[3];
    assign href_s = pins_s[4];
    assign ipos_s = pins_s[5];

    assign dir_src = ctrl_reg[`SDIO_CTRL_DIRSRC];
    assign pos_mode = ctrl_reg[`SDIO_CTRL_POSMODE];
    assign main_pwr = ctrl_reg[`SDIO_CTRL_MAINPWR];

    // APB: zero wait states, unmapped reads zero with error
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;

    // Direction decode
    always @* begin
        dir_next = cmd_dir_in;
        lock_next = 1'b0;
        if (dir_src) begin
            if (sel_a_s && !sel_b_s) begin
                dir_next = 1'b0;
            end else if (sel_b_s && !sel_a_s) begin
                dir_next = 1'b1;
            end else begin
                lock_next = 1'b1;
            end
        end else begin
            dir_next = cmd_dir_in ^ inv_s;
        end
    end

    // Absolute deviation
    always @* begin
        if (position_deviation_in[31]) begin
            abs_dev = 32'h0000_0000 - position_deviation_in;
        end else begin
            abs_dev = position_deviation_in;
        end
    end

    assign alarm_any = excess_deviation_alarm | (ext_alarm_code_in != 8'h00);

    // Delay restarts whenever power drops or an alarm appears
    sdio_ready_timer #(.CYCLES(READY_CYCLES)) u_ready (
        .pclk(pclk),
        .presetn(presetn),
        .run(main_pwr & ~alarm_any),
        .done(ready_done)
    );

    // Events
    always @* begin
        ev_next = {`SDIO_EV_W{1'b0}};
        ev_next[`SDIO_EV_DEVIATION] = (abs_dev > limit_reg)
            & ~excess_deviation_alarm;
        ev_next[`SDIO_EV_HOME_FOUND] = homing_active_out & href_s
            & ~home_prev_reg;
        ev_next[`SDIO_EV_IPOS_START] = ipos_s & ~ipos_prev_reg;
        ev_next[`SDIO_EV_READY] = ready_done & ~ready_prev_reg;
    end

    // Core state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            motor_dir_out <= 1'b0;
            motor_lock_out <= 1'b0;
            homing_active_out <= 1'b0;
            homed_reg <= 1'b0;
            home_prev_reg <= 1'b0;
            ipos_prev_reg <= 1'b0;
            ready_prev_reg <= 1'b0;
            internal_position_run_out <= 1'b0;
            internal_position_param_out <= 32'h0000_0000;
            excess_deviation_alarm <= 1'b0;
            servo_ready_out <= 1'b0;
            alarm_out <= 1'b0;
            position_complete_out <= 1'b0;
            alarm_code_out <= 8'h00;
        end else begin
            motor_dir_out <= dir_next;
            motor_lock_out <= lock_next;
            home_prev_reg <= href_s;
            ipos_prev_reg <= ipos_s;
            ready_prev_reg <= ready_done;
            // Homing runs until the reference edge
            if (hstart_s && !homing_active_out) begin
                homing_active_out <= 1'b1;
                homed_reg <= 1'b0;
            end else if (ev_next[`SDIO_EV_HOME_FOUND]) begin
                homing_active_out <= 1'b0;
                homed_reg <= 1'b1;
            end
            // Parameter latched at start so a run is consistent
            if (ev_next[`SDIO_EV_IPOS_START]) begin
                internal_position_run_out <= 1'b1;
                internal_position_param_out <= ipos_reg;
            end else if (!ipos_s) begin
                internal_position_run_out <= 1'b0;
            end
            // Alarm held until cleared via alarm register write
            if (abs_dev > limit_reg) begin
                excess_deviation_alarm <= 1'b1;
            end else if (wr_en && paddr == `SDIO_OFF_ALARM
                         && pwdata[0]) begin
                excess_deviation_alarm <= 1'b0;
            end
            alarm_out <= alarm_any;
            if (excess_deviation_alarm) begin
                alarm_code_out <= `SDIO_ALARM_DEV_CODE;
            end else begin
                alarm_code_out <= ext_alarm_code_in;
            end
            servo_ready_out <= ready_done & ~alarm_any;
            position_complete_out <= pos_mode
                & (abs_dev <= window_reg);
        end
    end

    // Register writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `SDIO_CTRL_RESET;
            window_reg <= `SDIO_WINDOW_RESET;
            limit_reg <= `SDIO_LIMIT_RESET;
            ipos_reg <= 32'h0000_0000;
            irq_mask_reg <= {`SDIO_EV_W{1'b0}};
            irq_stat_reg <= {`SDIO_EV_W{1'b0}};
        end else begin
            if (wr_en) begin
                if (paddr == `SDIO_OFF_CTRL) begin
                    ctrl_reg <= {29'h0, pwdata[2:0]};
                end else if (paddr == `SDIO_OFF_WINDOW) begin
                    window_reg <= pwdata;
                end else if (paddr == `SDIO_OFF_LIMIT) begin
                    limit_reg <= pwdata;
                end else if (paddr == `SDIO_OFF_IRQ_MASK) begin
                    irq_mask_reg <= pwdata[`SDIO_EV_W-1:0];
                end else if (paddr == `SDIO_OFF_IPOS) begin
                    ipos_reg <= pwdata;
                end
            end
            // Set wins over a same-cycle clear
            if (wr_en && paddr == `SDIO_OFF_IRQ_STAT) begin
                irq_stat_reg <= (irq_stat_reg & ~pwdata[`SDIO_EV_W-1:0])
                    | ev_next;
            end else begin
                irq_stat_reg <= irq_stat_reg | ev_next;
            end
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    assign status_w = {24'h0, ipos_s, homed_reg, homing_active_out,
        motor_dir_out, motor_lock_out, position_complete_out,
        alarm_out, servo_ready_out};

    // Read mux and error decode
    reg [31:0] rdata_next;
    reg mapped;
    always @* begin
        mapped = 1'b1;
        if (paddr == `SDIO_OFF_CTRL) begin
            rdata_next = ctrl_reg;
        end else if (paddr == `SDIO_OFF_WINDOW) begin
            rdata_next = window_reg;
        end else if (paddr == `SDIO_OFF_LIMIT) begin
            rdata_next = limit_reg;
        end else if (paddr == `SDIO_OFF_DEV) begin
            rdata_next = position_deviation_in;
        end else if (paddr == `SDIO_OFF_STATUS) begin
            rdata_next = status_w;
        end else if (paddr == `SDIO_OFF_IRQ_STAT) begin
            rdata_next = {28'h0, irq_stat_reg};
        end else if (paddr == `SDIO_OFF_IRQ_MASK) begin
            rdata_next = {28'h0, irq_mask_reg};
        end else if (paddr == `SDIO_OFF_ALARM) begin
            rdata_next = {23'h0, excess_deviation_alarm, alarm_code_out};
        end else if (paddr == `SDIO_OFF_IPOS) begin
            rdata_next = ipos_reg;
        end else begin
            rdata_next = 32'h0000_0000;
            mapped = 1'b0;
        end
    end

    // Read data taken in setup, so a flop drives it in the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdata_next;
        end
    end
    assign pslverr = psel & penable & ~mapped;
endmodule

// ---- sdio_top_sva.sv ----
`timescale 1ns/1ps
`include "sdio_consts.vh"
module sdio_top_sva #(
    parameter [31:0] READY_CYCLES = 32'h0000_0014
) (
    // Clock and APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    // Pins
    input wire direction_invert_in,
    input wire dir_select_a,
    input wire dir_select_b,
    input wire homing_start_in,
    input wire home_reference_in,
    input wire cmd_dir_in,
    input wire signed [31:0] position_deviation_in,
    input wire [7:0] ext_alarm_code_in,
    // Outputs
    input wire motor_dir_out,
    input wire motor_lock_out,
    input wire homing_active_out,
    input wire servo_ready_out,
    input wire alarm_out,
    input wire position_complete_out,
    input wire [7:0] alarm_code_out
);
    reg [2:0] ctrl_reg;
    reg [2:0] age_reg;
    reg [31:0] up_reg;
    wire ok = age_reg[2];
    wire due = up_reg > READY_CYCLES + 32'h3;
    wire [31:0] dev_abs = position_deviation_in[31] ?
        -position_deviation_in : position_deviation_in;
    // Age guard keeps pre-reset pin history out of the checks
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= 3'h0;
            age_reg <= 3'h0;
            up_reg <= 32'h0;
        end else begin
            if (psel && penable && pwrite && paddr == `SDIO_OFF_CTRL)
                ctrl_reg <= pwdata[2:0];
            if (!ok)
                age_reg <= age_reg + 3'h1;
            // Deviation over limit drops ready in the same cycle alarm_out rises
            if (!ctrl_reg[2] || ext_alarm_code_in != 8'h00 || alarm_out
                || dev_abs > `SDIO_LIMIT_RESET)
                up_reg <= 32'h0;
            else if (up_reg < READY_CYCLES + 32'h8)
                up_reg <= up_reg + 32'h1;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_pair_lock:
        assert property (ok && $past(ctrl_reg[0]) && $past(dir_select_a, 3)
            == $past(dir_select_b, 3) |-> motor_lock_out)
        else $error("lock missing");
    a_pair_dir:
        assert property (ok && $past(ctrl_reg[0]) && $past(dir_select_a, 3)
            != $past(dir_select_b, 3) |-> !motor_lock_out
            && motor_dir_out == $past(dir_select_b, 3))
        else $error("pair direction wrong");
    a_invert_dir:
        assert property (ok && !$past(ctrl_reg[0]) |-> !motor_lock_out &&
            motor_dir_out == ($past(cmd_dir_in) ^ $past(direction_invert_in, 3)))
        else $error("invert direction wrong");
    a_alarm_ext:
        assert property ((ok && ext_alarm_code_in != 8'h00)[*3] |-> alarm_out)
        else $error("alarm output missing");
    a_ready_due:
        assert property (due |-> servo_ready_out)
        else $error("ready late");
    a_complete_win:
        assert property (ok |-> position_complete_out == ($past(ctrl_reg[1])
            && $past(dev_abs) <= `SDIO_WINDOW_RESET))
        else $error("position complete wrong");
    a_dev_alarm:
        assert property (dev_abs > `SDIO_LIMIT_RESET |->
            ##[1:2] alarm_code_out == `SDIO_ALARM_DEV_CODE)
        else $error("deviation alarm missing");
    a_homing_start:
        assert property (ok && $rose(homing_start_in) && !homing_active_out
            && !home_reference_in |-> ##[2:4] homing_active_out)
        else $error("homing not started");
    cover property (motor_lock_out);
    cover property (servo_ready_out);
    cover property (alarm_code_out == `SDIO_ALARM_DEV_CODE);
endmodule
bind sdio_top sdio_top_sva #(.READY_CYCLES(READY_CYCLES)) u_sva (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .direction_invert_in,
    .dir_select_a, .dir_select_b, .homing_start_in, .home_reference_in,
    .cmd_dir_in, .position_deviation_in, .ext_alarm_code_in, .motor_dir_out,
    .motor_lock_out, .homing_active_out, .servo_ready_out, .alarm_out,
    .position_complete_out, .alarm_code_out);

// ---- sdio_host_pins.sv ----
`timescale 1ns/1ps
module sdio_host_pins (
    // Clock
    input wire pclk,
    // Requested levels
    input wire [5:0] want,
    // Pins
    output reg [5:0] pins
);
    // Levels move just after an edge, as a controller's outputs would
    initial pins = 6'h00;
    always @(posedge pclk) begin
        pins <= want;
    end
endmodule

// ---- sdio_top_bench.sv ----
`timescale 1ns/1ps
`include "sdio_consts.vh"
module sdio_top_bench;
    localparam [31:0] RC = 32'h0000_0014;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    reg cmd_dir_in = 0, err;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0, rd;
    reg signed [31:0] position_deviation_in = 0;
    reg [7:0] ext_alarm_code_in = 0;
    reg [5:0] want = 0;
    wire [5:0] pins;
    wire [31:0] prdata, ipos;
    wire [7:0] alarm_code_out;
    wire pready, pslverr, motor_dir_out, motor_lock_out, homing_active_out;
    wire run, servo_ready_out, alarm_out, position_complete_out, irq;
    integer fail_count = 0, check_count = 0, k, n;
    always #50 pclk = ~pclk;
    sdio_host_pins host (.pclk(pclk), .want(want), .pins(pins));
    sdio_top #(.READY_CYCLES(RC)) uut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .direction_invert_in(pins[0]), .dir_select_a(pins[1]),
        .dir_select_b(pins[2]), .homing_start_in(pins[3]),
        .home_reference_in(pins[4]), .internal_position_start_in(pins[5]),
        .cmd_dir_in, .position_deviation_in, .ext_alarm_code_in,
        .motor_dir_out, .motor_lock_out, .homing_active_out,
        .internal_position_run_out(run), .internal_position_param_out(ipos),
        .servo_ready_out, .alarm_out, .position_complete_out,
        .alarm_code_out, .irq);
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", check_count, fail_count);
            if (fail_count == 0 && check_count > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        begin
            check_count++;
            if (g !== e) begin
                fail_count++;
                $display("Error %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        integer i;
        begin
            @(posedge pclk);
            psel <= 1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1;
            for (i = 0; i < 16; i++) begin
                @(posedge pclk);
                if (pready === 1'b1) break;
            end
            if (i == 16) begin
                fail_count++;
                finish_test;
            end
            rd = prdata;
            err = pslverr;
            psel <= 0;
            penable <= 0;
        end
    endtask
    // Pin path is register, two sync flops and output register
    task step(input logic [5:0] w);
        begin
            want <= w;
            repeat (7) @(posedge pclk);
        end
    endtask
    task t_regs;
        begin
            apb(0, `SDIO_OFF_WINDOW, 0);
            chk("window", `SDIO_WINDOW_RESET, rd);
            apb(0, `SDIO_OFF_LIMIT, 0);
            chk("limit", `SDIO_LIMIT_RESET, rd);
            apb(0, 12'hFFC, 0);
            chk("slverr", 1, err);
            $display("regs done");
        end
    endtask
    task t_dir;
        begin
            apb(1, `SDIO_OFF_CTRL, 1);
            for (k = 0; k < 4; k++) begin
                cmd_dir_in <= k[0];
                step({3'h0, k[1], k[0], ~k[0]});
                chk("lock", k[1] == k[0], motor_lock_out);
                if (k[1] != k[0]) chk("dir", k[1], motor_dir_out);
            end
            apb(1, `SDIO_OFF_CTRL, 0);
            for (k = 0; k < 4; k++) begin
                cmd_dir_in <= k[1];
                step({5'h03, k[0]});
                chk("lock", 0, motor_lock_out);
                chk("dir", k[1] ^ k[0], motor_dir_out);
            end
            $display("direction done");
        end
    endtask
    task t_ready;
        begin
            apb(1, `SDIO_OFF_CTRL, 4);
            for (n = 0; n < 100 && servo_ready_out !== 1'b1; n++)
                @(posedge pclk);
            if (n == 100) begin
                fail_count++;
                finish_test;
            end
            chk("ready", 1, n >= RC && n <= RC + 4);
            ext_alarm_code_in <= 8'h05;
            repeat (4) @(posedge pclk);
            chk("alarm", 1, alarm_out);
            chk("ready", 0, servo_ready_out);
            ext_alarm_code_in <= 8'h00;
            repeat (4) @(posedge pclk);
            chk("alarm", 0, alarm_out);
            $display("ready done");
        end
    endtask
    task t_pos;
        begin
            apb(1, `SDIO_OFF_CTRL, 6);
            apb(1, `SDIO_OFF_IRQ_MASK, 1);
            position_deviation_in <= -10;
            repeat (3) @(posedge pclk);
            chk("complete", 1, position_complete_out);
            position_deviation_in <= 11;
            repeat (3) @(posedge pclk);
            chk("complete", 0, position_complete_out);
            position_deviation_in <= 30001;
            repeat (3) @(posedge pclk);
            chk("code", `SDIO_ALARM_DEV_CODE, alarm_code_out);
            chk("alarm", 1, alarm_out);
            chk("irq", 1, irq);
            position_deviation_in <= 0;
            apb(1, `SDIO_OFF_ALARM, 1);
            apb(1, `SDIO_OFF_IRQ_STAT, 1);
            repeat (2) @(posedge pclk);
            chk("alarm", 0, alarm_out);
            chk("irq", 0, irq);
            apb(1, `SDIO_OFF_IRQ_MASK, 0);
            position_deviation_in <= -30001;
            repeat (3) @(posedge pclk);
            position_deviation_in <= 0;
            chk("irq", 0, irq);
            apb(0, `SDIO_OFF_IRQ_STAT, 0);
            chk("irq_stat", 1, rd & 32'h1);
            apb(1, `SDIO_OFF_ALARM, 1);
            $display("position done");
        end
    endtask
    task t_home;
        begin
            apb(1, `SDIO_OFF_IPOS, 32'h0000_0123);
            step(6'h08);
            chk("homing", 1, homing_active_out);
            step(6'h10);
            chk("homing", 0, homing_active_out);
            apb(0, `SDIO_OFF_STATUS, 0);
            chk("homed", 1, rd[`SDIO_ST_HOMED]);
            step(6'h20);
            chk("run", 1, run);
            chk("param", 32'h0000_0123, ipos);
            $display("home done");
        end
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        t_regs;
        t_dir;
        t_ready;
        t_pos;
        t_home;
        finish_test;
    end
endmodule
